// ===== irsa_defines.svh
// Register offsets, field positions and reset values of the range bank.
// Notes on behaviour
// [R1] - Low register index 0x04, resets 0x00ff.
// [R2] - High register index 0x05, resets 0x00ff.
// [R3] - Bits 15:9 address, bit 8 reserved zero; the code stores a lane 1 write into bit 8.
// [R4] - Codes 00/11 10 V, 01 2.5 V, 10 5 V.
// [R5] - Low register: inputs 0..3 in two-bit fields.
// [R6] - High register: inputs 4..7 in two-bit fields.
// [R7] - Fields reset to 3, all read/write.
// [R8] - Each input picks one of three bipolar ranges.
// [R9] - New setting applies from the next conversion.
`ifndef IRSA_DEFINES_SVH
`define IRSA_DEFINES_SVH

// Register indices; the byte address on the bus is four times the index.
`define IRSA_IDX_LOW 7'h04
`define IRSA_IDX_HIGH 7'h05
`define IRSA_ADDR_LOW 8'h10
`define IRSA_ADDR_HIGH 8'h14

// Field layout of a register word.
`define IRSA_ADDR_MSB 15
`define IRSA_ADDR_LSB 9
`define IRSA_RSVD_BIT 8
`define IRSA_FIELD_W 2
`define IRSA_FIELDS_PER_REG 4

// Reset values.
`define IRSA_RESET_FIELDS 8'hff
`define IRSA_RESET_RSVD 1'h0

// Bus answers.
`define IRSA_RESP_OKAY 2'h0
`define IRSA_RESP_SLVERR 2'h2

`endif

// ===== irsa_pkg.sv
// Types shared by the range bank modules.
package irsa_pkg;

	// Two-bit range code of one input.
	typedef enum logic [1:0] {
		IRSA_RANGE_10V_A = 2'h0,
		IRSA_RANGE_2V5 = 2'h1,
		IRSA_RANGE_5V = 2'h2,
		IRSA_RANGE_10V_B = 2'h3
	} irsa_range_t;

endpackage

// ===== irsa_range_apply.sv
// Snapshot and decode of the range codes used by the converter.
`timescale 1ns/1ps
`include "irsa_defines.svh"

module irsa_range_apply
	import irsa_pkg::*;
#(
	parameter int NUM_INPUTS = 8
) (
	// Clock and reset.
	input wire logic clk,
	input wire logic rst,
	// Live settings and conversion start.
	input wire logic [2*NUM_INPUTS-1:0] codes,
	input wire logic load,
	// Applied settings, one-hot per input.
	output logic [NUM_INPUTS-1:0] sel_10v,
	output logic [NUM_INPUTS-1:0] sel_5v,
	output logic [NUM_INPUTS-1:0] sel_2v5
);

	genvar i;
	generate
		for (i = 0; i < NUM_INPUTS; i++) begin : g_in
			irsa_range_t code;
			assign code = irsa_range_t'(codes[2*i +: 2]);
			// Settings are sampled only at a conversion start. [R9]
			always_ff @(posedge clk or posedge rst) begin
				if (rst) begin
					sel_10v[i] <= 1'b1;
					sel_5v[i] <= 1'b0;
					sel_2v5[i] <= 1'b0;
				end else if (load) begin
					unique case (code) // [R4] [R8]
						IRSA_RANGE_10V_A, IRSA_RANGE_10V_B: begin
							sel_10v[i] <= 1'b1;
							sel_5v[i] <= 1'b0;
							sel_2v5[i] <= 1'b0;
						end
						IRSA_RANGE_5V: begin
							sel_10v[i] <= 1'b0;
							sel_5v[i] <= 1'b1;
							sel_2v5[i] <= 1'b0;
						end
						IRSA_RANGE_2V5: begin
							sel_10v[i] <= 1'b0;
							sel_5v[i] <= 1'b0;
							sel_2v5[i] <= 1'b1;
						end
					endcase
				end
			end
		end
	endgenerate

endmodule

// ===== irsa_range_bank.sv
// Converter-A input range registers behind an AXI4-Lite slave.
//
// Decided for this implementation: the AXI4-Lite slave port.
`timescale 1ns/1ps
`include "irsa_defines.svh"

module irsa_range_bank
	import irsa_pkg::*;
#(
	parameter int NUM_INPUTS = 8
) (
	// Clock and reset.
	input wire logic REF_CLK,
	input wire logic RST,
	// AXI4-Lite write address.
	input wire logic [7:0] S_AXI_AWADDR,
	input wire logic S_AXI_AWVALID,
	output logic S_AXI_AWREADY,
	// AXI4-Lite write data.
	input wire logic [31:0] S_AXI_WDATA,
	input wire logic [3:0] S_AXI_WSTRB,
	input wire logic S_AXI_WVALID,
	output logic S_AXI_WREADY,
	// AXI4-Lite write response.
	output logic [1:0] S_AXI_BRESP,
	output logic S_AXI_BVALID,
	input wire logic S_AXI_BREADY,
	// AXI4-Lite read address.
	input wire logic [7:0] S_AXI_ARADDR,
	input wire logic S_AXI_ARVALID,
	output logic S_AXI_ARREADY,
	// AXI4-Lite read data.
	output logic [31:0] S_AXI_RDATA,
	output logic [1:0] S_AXI_RRESP,
	output logic S_AXI_RVALID,
	input wire logic S_AXI_RREADY,
	// Conversion side.
	input wire logic CONV_START,
	output logic [NUM_INPUTS-1:0] RANGE_10V,
	output logic [NUM_INPUTS-1:0] RANGE_5V,
	output logic [NUM_INPUTS-1:0] RANGE_2V5
);

	// Stored register contents.
	logic [7:0] range_low;
	logic [7:0] range_high;
	logic rsvd_low;
	logic rsvd_high;

	// Write channel holding state.
	logic aw_held;
	logic w_held;
	logic [7:0] aw_addr;
	logic [31:0] w_data;
	logic [3:0] w_strb;
	logic do_write;

	// Read path.
	logic [31:0] next_rdata;
	logic [1:0] next_rresp;

	// A channel is ready while nothing of its kind is held and no response of its kind is pending.
	assign S_AXI_AWREADY = !aw_held && !S_AXI_BVALID;
	assign S_AXI_WREADY = !w_held && !S_AXI_BVALID;
	assign S_AXI_ARREADY = !S_AXI_RVALID;
	assign do_write = aw_held && w_held && !S_AXI_BVALID;

	// Address and data are taken in either order and held until both exist.
	always_ff @(posedge REF_CLK or posedge RST) begin
		if (RST) begin
			aw_held <= 1'b0;
			w_held <= 1'b0;
			aw_addr <= 8'h00;
			w_data <= 32'h0;
			w_strb <= 4'h0;
		end else if (do_write) begin
			aw_held <= 1'b0;
			w_held <= 1'b0;
		end else begin
			if (S_AXI_AWVALID && S_AXI_AWREADY) begin
				aw_held <= 1'b1;
				aw_addr <= S_AXI_AWADDR;
			end
			if (S_AXI_WVALID && S_AXI_WREADY) begin
				w_held <= 1'b1;
				w_data <= S_AXI_WDATA;
				w_strb <= S_AXI_WSTRB;
			end
		end
	end

	// Write response one cycle after both halves are present.
	always_ff @(posedge REF_CLK or posedge RST) begin
		if (RST) begin
			S_AXI_BVALID <= 1'b0;
			S_AXI_BRESP <= `IRSA_RESP_OKAY;
		end else if (do_write) begin
			S_AXI_BVALID <= 1'b1;
			if (aw_addr[7:2] == `IRSA_ADDR_LOW >> 2 ||
				aw_addr[7:2] == `IRSA_ADDR_HIGH >> 2) begin
				S_AXI_BRESP <= `IRSA_RESP_OKAY;
			end else begin
				S_AXI_BRESP <= `IRSA_RESP_SLVERR;
			end
		end else if (S_AXI_BREADY) begin
			S_AXI_BVALID <= 1'b0;
		end
	end

	// Range fields; byte lane 0 holds the fields, lane 1 the reserved bit.
	always_ff @(posedge REF_CLK or posedge RST) begin
		if (RST) begin
			range_low <= `IRSA_RESET_FIELDS; // [R1] [R7]
			range_high <= `IRSA_RESET_FIELDS; // [R2] [R7]
			rsvd_low <= `IRSA_RESET_RSVD; // [R3]
			rsvd_high <= `IRSA_RESET_RSVD; // [R3]
		end else if (do_write) begin
			if (aw_addr[7:2] == `IRSA_ADDR_LOW >> 2) begin
				if (w_strb[0]) begin
					range_low <= w_data[7:0]; // [R5] [R7]
				end
				if (w_strb[1]) begin
					rsvd_low <= w_data[`IRSA_RSVD_BIT];
				end
			end
			if (aw_addr[7:2] == `IRSA_ADDR_HIGH >> 2) begin
				if (w_strb[0]) begin
					range_high <= w_data[7:0]; // [R6] [R7]
				end
				if (w_strb[1]) begin
					rsvd_high <= w_data[`IRSA_RSVD_BIT];
				end
			end
		end
	end

	// Read word: the register index sits in bits 15:9.
	always_comb begin
		next_rdata = 32'h0;
		next_rresp = `IRSA_RESP_OKAY;
		if (S_AXI_ARADDR[7:2] == `IRSA_ADDR_LOW >> 2) begin
			next_rdata[15:0] = {`IRSA_IDX_LOW, rsvd_low, range_low}; // [R3]
		end else if (S_AXI_ARADDR[7:2] == `IRSA_ADDR_HIGH >> 2) begin
			next_rdata[15:0] = {`IRSA_IDX_HIGH, rsvd_high, range_high}; // [R3]
		end else begin
			next_rresp = `IRSA_RESP_SLVERR;
		end
	end

	// Read answer one cycle after the address is taken.
	always_ff @(posedge REF_CLK or posedge RST) begin
		if (RST) begin
			S_AXI_RVALID <= 1'b0;
			S_AXI_RDATA <= 32'h0;
			S_AXI_RRESP <= `IRSA_RESP_OKAY;
		end else if (S_AXI_ARVALID && S_AXI_ARREADY) begin
			S_AXI_RVALID <= 1'b1;
			S_AXI_RDATA <= next_rdata;
			S_AXI_RRESP <= next_rresp;
		end else if (S_AXI_RREADY) begin
			S_AXI_RVALID <= 1'b0;
		end
	end

	// Applied ranges change only at a conversion start. [R9]
	irsa_range_apply #(
		.NUM_INPUTS(NUM_INPUTS)
	) u_apply (
		.clk(REF_CLK),
		.rst(RST),
		.codes({range_high, range_low}),
		.load(CONV_START),
		.sel_10v(RANGE_10V),
		.sel_5v(RANGE_5V),
		.sel_2v5(RANGE_2V5)
	);

endmodule

// ===== irsa_range_bank_monitor.sv
// Concurrent checks on the range bank ports.
`timescale 1ns/1ps
module irsa_range_bank_monitor #(
	parameter int NUM_INPUTS = 8
) (
	// Clock, reset and bus handshakes.
	input wire logic REF_CLK, RST, S_AXI_AWVALID, S_AXI_AWREADY,
	input wire logic S_AXI_WVALID, S_AXI_WREADY, S_AXI_BVALID,
	input wire logic S_AXI_ARVALID, S_AXI_ARREADY, S_AXI_RVALID,
	input wire logic [7:0] S_AXI_ARADDR,
	input wire logic [31:0] S_AXI_RDATA,
	input wire logic [1:0] S_AXI_RRESP,
	// Conversion side.
	input wire logic CONV_START,
	input wire logic [NUM_INPUTS-1:0] RANGE_10V, RANGE_5V, RANGE_2V5
);
	default clocking @(posedge REF_CLK); endclocking
	default disable iff (RST);
	AST_IDX_LOW: assert property (S_AXI_ARVALID && S_AXI_ARREADY &&
		S_AXI_ARADDR[7:2] == 6'h04 |=> S_AXI_RVALID &&
		S_AXI_RDATA[15:9] == 7'h04 && S_AXI_RRESP == 2'h0)
		else $error("low index");
	AST_IDX_HIGH: assert property (S_AXI_ARVALID && S_AXI_ARREADY &&
		S_AXI_ARADDR[7:2] == 6'h05 |=> S_AXI_RVALID &&
		S_AXI_RDATA[15:9] == 7'h05 && S_AXI_RRESP == 2'h0)
		else $error("high index");
	AST_UPPER_ZERO: assert property (
		S_AXI_RVALID |-> S_AXI_RDATA[31:16] == 16'h0) else $error("upper");
	AST_ALL_SET: assert property (
		(RANGE_10V | RANGE_5V | RANGE_2V5) == {NUM_INPUTS{1'b1}})
		else $error("no range");
	AST_ONE_HOT: assert property (((RANGE_10V & RANGE_5V) |
		(RANGE_10V & RANGE_2V5) | (RANGE_5V & RANGE_2V5)) == '0)
		else $error("two ranges");
	AST_HOLD: assert property (!CONV_START |=> $stable(RANGE_10V) &&
		$stable(RANGE_5V) && $stable(RANGE_2V5)) else $error("moved");
	AST_RST_WIDE: assert property (
		$fell(RST) |-> RANGE_10V == {NUM_INPUTS{1'b1}}) else $error("rst");
	// Both halves taken at one edge: the answer stands two edges later.
	AST_WR_RESP: assert property (S_AXI_AWVALID && S_AXI_AWREADY &&
		S_AXI_WVALID && S_AXI_WREADY |-> ##2 S_AXI_BVALID)
		else $error("bresp");
endmodule

// ===== irsa_host.sv
// Host model that masters the register bus.
`timescale 1ns/1ps
module irsa_host (
	// Clock and bus.
	input wire logic REF_CLK, S_AXI_AWREADY, S_AXI_WREADY,
	input wire logic S_AXI_BVALID, S_AXI_ARREADY, S_AXI_RVALID,
	output logic [7:0] S_AXI_AWADDR = 0, S_AXI_ARADDR = 0,
	output logic [31:0] S_AXI_WDATA = 0,
	output logic [3:0] S_AXI_WSTRB = 0,
	output logic S_AXI_AWVALID = 0, S_AXI_WVALID = 0, S_AXI_BREADY = 0,
	output logic S_AXI_ARVALID = 0, S_AXI_RREADY = 0
);
	logic ta, tw, tb;
	// Write; released address and data lines show the inverse, while the strobes keep the stale value.
	task automatic wr(input logic [7:0] a, input logic [31:0] d,
		input logic [3:0] s);
		S_AXI_AWADDR <= a;
		S_AXI_WDATA <= d;
		S_AXI_WSTRB <= s;
		{S_AXI_AWVALID, S_AXI_WVALID, S_AXI_BREADY} <= 3'h7;
		forever begin
			@(negedge REF_CLK);
			{ta, tw, tb} = {S_AXI_AWREADY, S_AXI_WREADY, S_AXI_BVALID};
			@(posedge REF_CLK);
			if (ta) {S_AXI_AWVALID, S_AXI_AWADDR} <= {1'b0, ~a};
			if (tw) {S_AXI_WVALID, S_AXI_WDATA} <= {1'b0, ~d};
			if (tb) S_AXI_BREADY <= 1'b0;
			if (tb) break;
		end
	endtask
	// Read; RREADY stays up until the data is taken.
	task automatic rd(input logic [7:0] a);
		S_AXI_ARADDR <= a;
		{S_AXI_ARVALID, S_AXI_RREADY} <= 2'h3;
		forever begin
			@(negedge REF_CLK);
			{ta, tb} = {S_AXI_ARREADY, S_AXI_RVALID};
			@(posedge REF_CLK);
			if (ta) {S_AXI_ARVALID, S_AXI_ARADDR} <= {1'b0, ~a};
			if (tb) S_AXI_RREADY <= 1'b0;
			if (tb) break;
		end
	endtask
endmodule

// ===== irsa_range_bank_tb_top.sv
// Self-checking bench of the range bank.
`timescale 1ns/1ps
module irsa_range_bank_tb_top;
	logic REF_CLK = 0, RST = 1, CONV_START = 0, cs_d = 0;
	logic [7:0] S_AXI_AWADDR, S_AXI_ARADDR, RANGE_10V, RANGE_5V, RANGE_2V5;
	logic [31:0] S_AXI_WDATA, S_AXI_RDATA;
	logic [3:0] S_AXI_WSTRB;
	logic [1:0] S_AXI_BRESP, S_AXI_RRESP;
	logic S_AXI_AWVALID, S_AXI_AWREADY, S_AXI_WVALID, S_AXI_WREADY;
	logic S_AXI_BVALID, S_AXI_BREADY, S_AXI_ARVALID, S_AXI_ARREADY;
	logic S_AXI_RVALID, S_AXI_RREADY;
	logic [33:0] q[$];
	logic [8:0] m[2] = '{9'h0ff, 9'h0ff};
	int seed = 76, fail_count = 0, n_tests = 0;
	irsa_range_bank DUT (.*);
	irsa_host h (.*);
	always #2.5 REF_CLK = ~REF_CLK;
	task automatic tally_and_finish;
		$display("checks %0d errors %0d", n_tests, fail_count);
		if (fail_count == 0 && n_tests > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask
	task automatic chk(input logic [33:0] s, input logic [33:0] e);
		n_tests++;
		if (s !== e) begin
			fail_count++;
			$display("[ERR] %0t seen %h exp %h", $time, s, e);
		end
	endtask
	// Range one-hot expected per input: 10 V, 5 V, 2.5 V groups.
	function automatic logic [23:0] dec(input logic [15:0] f);
		logic [23:0] e;
		e = '0;
		for (int i = 0; i < 8; i++) begin
			case (f[2*i+:2])
				2'h1: e[i] = 1'b1;
				2'h2: e[8+i] = 1'b1;
				default: e[16+i] = 1'b1;
			endcase
		end
		return e;
	endfunction
	// Write, read back, then snapshot; r above 1 is an unmapped place.
	task automatic run(input logic [1:0] r, input logic [31:0] d,
		input logic [3:0] s);
		logic [7:0] a;
		a = 8'h10 + {4'h0, r, 2'h0};
		q.push_back(r[1] ? 34'h200000000 : 34'h0);
		h.wr(a, d, s);
		if (!r[1] && s[0]) m[r[0]][7:0] = d[7:0];
		if (!r[1] && s[1]) m[r[0]][8] = d[8];
		q.push_back(r[1] ? 34'h200000000 : {18'h0, 6'h2, r[0], m[r[0]]});
		h.rd(a);
		CONV_START <= 1'b1;
		q.push_back({10'h0, dec({m[1][7:0], m[0][7:0]})});
		@(posedge REF_CLK);
		CONV_START <= 1'b0;
	endtask
	// Compare each answer or snapshot with the oldest note.
	always @(negedge REF_CLK) begin
		if (S_AXI_BVALID && S_AXI_BREADY)
			chk({S_AXI_BRESP, 32'h0}, q.pop_front());
		if (S_AXI_RVALID && S_AXI_RREADY)
			chk({S_AXI_RRESP, S_AXI_RDATA}, q.pop_front());
		if (cs_d)
			chk({10'h0, RANGE_10V, RANGE_5V, RANGE_2V5}, q.pop_front());
		cs_d = CONV_START;
	end
	initial begin
		#50000;
		fail_count++;
		tally_and_finish;
	end
	initial begin
		repeat (3) @(posedge REF_CLK);
		RST <= 1'b0;
		run(2'h0, 32'h0, 4'h0);
		run(2'h1, 32'h0, 4'h0);
		run(2'h1, 32'hffffffe4, 4'h3);
		repeat (8) run(2'($random(seed)), $random(seed), 4'($random(seed)));
		tally_and_finish;
	end
endmodule
bind irsa_range_bank irsa_range_bank_monitor #(.NUM_INPUTS(NUM_INPUTS))
	MON (.*);
